// *** rtl/swpc_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1: Strong pullup reuses the active pullup transistor
// R2: Strong pullup slot rising edge acts like active pullup
// R3: Strong pullup holds until command, disable, reset
// R4: Strong pullup end clears its enable automatically
// R5: Strong pullup leaves active pullup setting alone
// R6: Active pullup starts only on low-to-high crossing
// R7: No active pullup outside reset cycles, slots
// R8: Trigger arms when initial low interval ends
// R9: Reset: low, arm, on for pullup duration
// R10: Reset: rearm for presence end, hold to end
// R11: Write-zero: low, arm, hold until recovery ends
// R12: Write-one: low, arm, hold through long recovery
// R13: Read: low for write-one time, then pullup, arm
// R14: Read: sample line at sample time from start
// R15: Slave releases zero after its response time
// R16: Read-one pullup holds to long slot end
// R17: Software normally enables active line pullup
// R18: Software arms strong pullup before slot commands
// R19: Overdrive selects fast timing for every waveform
// R20: All intervals come from programmable timing words
module swpc_ctrl (
  input wire logic core_clk,           // Core clock, 50 MHz
  input wire logic resetn,             // Async reset, active low
  input wire logic [7:0] reg_addr,     // Register byte address
  input wire logic [31:0] reg_wdata,   // Register write data
  input wire logic reg_wr,             // Write strobe
  input wire logic reg_rd,             // Read strobe
  output logic [31:0] reg_rdata,       // Read data, cycle after strobe
  input wire logic line_in,            // Line above pullup_on_threshold
  output logic line_low_oe,            // Drive line low
  output logic normal_pullup_en,       // normal_pullup_resistor on
  output logic apu_drive               // active_pullup_impedance on
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic apu_en;                   // active_line_pullup enable
    logic spu_arm;                  // Strong pullup enable
    logic spu_rearm;                // Arm written while conducting
    logic od;                       // Overdrive speed
    logic pend;                     // Slot waiting for next tick
    swpc_pkg::swpc_slot_t slot;     // Current slot kind
    swpc_pkg::swpc_phase_t phase;   // Sequencer phase
    logic [15:0] phase_cnt;         // Ticks in phase
    logic [15:0] slot_cnt;          // Ticks since slot start
    logic [15:0] apu_cnt;           // Ticks since trigger
    logic armed;                    // Trigger armed
    logic apu_on;                   // Active pullup conducting
    logic first_done;               // Reset: first pulse over
    logic spu_active;               // Strong pullup conducting
    logic read_bit;                 // Sampled read value
    logic line_q;                   // Previous line level
    logic low_oe;                   // Line low driver
    logic pu_en;                    // Normal pullup resistor
    logic apu_out;                  // Pullup transistor
    logic [31:0] rdata;             // Read data
  } swpc_st_t;

  swpc_st_t st_r;    // State
  swpc_st_t st_nxt;  // Next state

  logic tick;               // Timing unit enable
  logic [15:0] time_a;      // Phase length word
  logic [15:0] time_b;      // Pulse length or sample time word
  logic [3:0] idx_a;        // Phase word index
  logic [3:0] idx_b;        // Second word index
  logic tmem_wr;            // Timing word write

  // ****************************************************************
  // Phase to timing word decode
  // ****************************************************************
  // Word that ends the given phase of the given slot
  function automatic logic [2:0] phase_word(
    input swpc_pkg::swpc_phase_t ph,
    input swpc_pkg::swpc_slot_t sl
  );
    logic [2:0] w;
    w = swpc_pkg::T_REC;
    case (ph)
      swpc_pkg::SWPC_IDLE, swpc_pkg::SWPC_LOW: begin
        case (sl)
          swpc_pkg::SWPC_SLOT_RST: w = swpc_pkg::T_RSTL;
          swpc_pkg::SWPC_SLOT_W0: w = swpc_pkg::T_W0L;
          default: w = swpc_pkg::T_W1L;
        endcase
      end
      swpc_pkg::SWPC_HIGH1: begin
        if (sl == swpc_pkg::SWPC_SLOT_RST) begin
          w = swpc_pkg::T_RSTH;
        end else begin
          w = swpc_pkg::T_W0L;
        end
      end
      default: w = swpc_pkg::T_REC;
    endcase
    return w;
  endfunction

  // Speed set chosen by overdrive bit [R19] [R20]
  assign idx_a = {st_r.od, phase_word(st_r.phase, st_r.slot)};
  assign idx_b = {st_r.od, (st_r.slot == swpc_pkg::SWPC_SLOT_RD) ?
                  swpc_pkg::T_MSR : swpc_pkg::T_APU};
  assign tmem_wr = reg_wr && (reg_addr[7:6] == swpc_pkg::TIME_PAGE);

  // ****************************************************************
  // Submodules
  // ****************************************************************
  swpc_tick u_tick (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(tick)
  );

  swpc_tmem u_tmem (
    .core_clk(core_clk),
    .resetn(resetn),
    .wr_en(tmem_wr),
    .wr_idx(reg_addr[5:2]),
    .wr_data(reg_wdata[15:0]),
    .rd_a_idx(idx_a),
    .rd_b_idx(idx_b),
    .rd_a(time_a),
    .rd_b(time_b)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic rise;          // Line crossed threshold upward
    logic cmd_go;        // Slot command accepted
    logic spu_end;       // Strong pullup stops now
    logic phase_done;    // Current phase interval elapsed
    logic [15:0] p_inc;  // Phase count after tick
    logic [15:0] s_inc;  // Slot count after tick
    logic [15:0] a_inc;  // Pulse count after tick
    rise = 1'b0;
    cmd_go = 1'b0;
    spu_end = 1'b0;
    phase_done = 1'b0;
    p_inc = st_r.phase_cnt + 16'h0001;
    s_inc = st_r.slot_cnt + 16'h0001;
    a_inc = st_r.apu_cnt + 16'h0001;
    st_nxt = st_r;
    st_nxt.line_q = line_in;
    st_nxt.rdata = 32'h0000_0000;
    // Only a low-to-high crossing of the threshold triggers [R6]
    rise = line_in && !st_r.line_q;

    // Register writes
    if (reg_wr && reg_addr == swpc_pkg::ADDR_CTRL) begin
      st_nxt.apu_en = reg_wdata[swpc_pkg::CTRL_APU];
      st_nxt.od = reg_wdata[swpc_pkg::CTRL_OD];
      st_nxt.spu_arm = reg_wdata[swpc_pkg::CTRL_SPU];
      if (st_r.spu_active && reg_wdata[swpc_pkg::CTRL_SPU]) begin
        st_nxt.spu_rearm = 1'b1;
      end
      // Software disable ends conduction [R3]
      if (!reg_wdata[swpc_pkg::CTRL_SPU]) begin
        spu_end = 1'b1;
        st_nxt.spu_rearm = 1'b0;
      end
    end
    if (reg_wr && reg_addr == swpc_pkg::ADDR_CMD &&
        st_r.phase == swpc_pkg::SWPC_IDLE && !st_r.pend) begin
      cmd_go = 1'b1;
      st_nxt.pend = 1'b1;
      st_nxt.slot = swpc_pkg::swpc_slot_t'(reg_wdata[1:0]);
      // New bus communication ends conduction [R3]
      spu_end = 1'b1;
    end

    // Slot start waits for a tick so the timing words settle
    if (st_r.pend && tick) begin
      st_nxt.pend = 1'b0;
      st_nxt.phase = swpc_pkg::SWPC_LOW;
      st_nxt.phase_cnt = 16'h0000;
      st_nxt.slot_cnt = 16'h0000;
      st_nxt.first_done = 1'b0;
    end

    // Interval counting
    if (tick && st_r.phase != swpc_pkg::SWPC_IDLE) begin
      st_nxt.phase_cnt = p_inc;
      st_nxt.slot_cnt = s_inc;
      if (st_r.phase == swpc_pkg::SWPC_HIGH1 &&
          st_r.slot != swpc_pkg::SWPC_SLOT_RST) begin
        phase_done = (s_inc >= time_a);
      end else begin
        phase_done = (p_inc >= time_a);
      end
      // Read value taken at sample time from slot start [R14]
      if (st_r.slot == swpc_pkg::SWPC_SLOT_RD && s_inc == time_b) begin
        st_nxt.read_bit = line_in;
      end
    end

    // Phase sequencing
    case (st_r.phase)
      swpc_pkg::SWPC_IDLE: begin
        st_nxt.armed = 1'b0;
      end
      swpc_pkg::SWPC_LOW: begin
        if (phase_done) begin
          st_nxt.phase_cnt = 16'h0000;
          // Arm right after the initial low interval [R8] [R9] [R13]
          st_nxt.armed = st_r.apu_en || st_r.spu_arm; // [R2]
          // Write-zero goes straight to recovery [R11]
          if (st_r.slot == swpc_pkg::SWPC_SLOT_W0) begin
            st_nxt.phase = swpc_pkg::SWPC_HIGH2;
          end else begin
            st_nxt.phase = swpc_pkg::SWPC_HIGH1;
          end
        end
      end
      swpc_pkg::SWPC_HIGH1: begin
        if (phase_done) begin
          st_nxt.phase_cnt = 16'h0000;
          if (st_r.slot == swpc_pkg::SWPC_SLOT_RST) begin
            st_nxt.phase = swpc_pkg::SWPC_IDLE; // [R10]
          end else begin
            // Then recovery: slot ends at w0l plus rec [R12] [R16]
            st_nxt.phase = swpc_pkg::SWPC_HIGH2;
          end
        end
      end
      swpc_pkg::SWPC_HIGH2: begin
        if (phase_done) begin
          st_nxt.phase_cnt = 16'h0000;
          st_nxt.phase = swpc_pkg::SWPC_IDLE; // [R11]
        end
      end
      default: begin
        st_nxt.phase = swpc_pkg::SWPC_IDLE;
      end
    endcase

    // Trigger: fires only while armed inside a cycle or slot [R7]
    if (st_r.armed && rise && st_r.phase != swpc_pkg::SWPC_IDLE &&
        st_r.phase != swpc_pkg::SWPC_LOW) begin
      st_nxt.armed = 1'b0;
      st_nxt.apu_on = 1'b1;
      st_nxt.apu_cnt = 16'h0000;
      if (st_r.spu_arm && st_r.slot != swpc_pkg::SWPC_SLOT_RST) begin
        st_nxt.spu_active = 1'b1;
      end
    end else if (st_r.apu_on && tick) begin
      st_nxt.apu_cnt = a_inc;
      // Reset cycle: first pulse lasts the pullup duration [R9]
      if (st_r.slot == swpc_pkg::SWPC_SLOT_RST && !st_r.first_done &&
          a_inc >= time_b) begin
        st_nxt.apu_on = 1'b0;
        st_nxt.first_done = 1'b1;
        st_nxt.armed = 1'b1; // [R10]
      end
    end

    // Slot end drops the active pullup and any leftover arm [R7]
    if (st_nxt.phase == swpc_pkg::SWPC_IDLE) begin
      st_nxt.apu_on = 1'b0;
      st_nxt.armed = 1'b0;
    end

    // Ending conduction clears the enable, unless rearmed [R3] [R4]
    if (spu_end && st_r.spu_active) begin
      st_nxt.spu_active = 1'b0;
      st_nxt.spu_arm = st_nxt.spu_rearm;
      st_nxt.spu_rearm = 1'b0;
    end
    // The active pullup enable is never touched here [R5]

    // Self-clearing master reset returns control to defaults [R3]
    if (reg_wr && reg_addr == swpc_pkg::ADDR_CTRL &&
        reg_wdata[swpc_pkg::CTRL_MRST]) begin
      st_nxt = '0;
      st_nxt.line_q = line_in;
    end

    // Register reads, data valid for one cycle
    if (reg_rd) begin
      case (reg_addr)
        swpc_pkg::ADDR_CTRL: begin
          st_nxt.rdata[swpc_pkg::CTRL_APU] = st_r.apu_en;
          st_nxt.rdata[swpc_pkg::CTRL_SPU] = st_r.spu_arm;
          st_nxt.rdata[swpc_pkg::CTRL_OD] = st_r.od;
        end
        swpc_pkg::ADDR_STAT: begin
          st_nxt.rdata[swpc_pkg::STAT_BUSY] =
            st_r.pend || (st_r.phase != swpc_pkg::SWPC_IDLE);
          st_nxt.rdata[swpc_pkg::STAT_BIT] = st_r.read_bit;
          st_nxt.rdata[swpc_pkg::STAT_SPU] = st_r.spu_active;
          st_nxt.rdata[swpc_pkg::STAT_APU] = st_r.apu_out;
          st_nxt.rdata[swpc_pkg::STAT_ARM] = st_r.armed;
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Pin drivers from the next state, one transistor for both [R1]
    st_nxt.low_oe = (st_nxt.phase == swpc_pkg::SWPC_LOW);
    st_nxt.pu_en = !st_nxt.low_oe; // [R13]
    st_nxt.apu_out = st_nxt.apu_on || st_nxt.spu_active; // [R1]
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = st_r.rdata;
  assign line_low_oe = st_r.low_oe;
  assign normal_pullup_en = st_r.pu_en;
  assign apu_drive = st_r.apu_out;

endmodule
`default_nettype wire

// *** rtl/swpc_pkg.sv ***
// ****************************************************************
// Shared constants for the pullup controller
// ****************************************************************
package swpc_pkg;

  // Core clock and slot tick
  localparam int unsigned CLK_NS = 20;       // Core clock period
  localparam int unsigned TICK_NS = 100;     // Timing unit of all intervals
  localparam int unsigned TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] TICK_LAST = 4'(TICK_CYC - 1); // Divider wrap

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;  // Control register
  localparam logic [7:0] ADDR_CMD = 8'h04;   // Slot command register
  localparam logic [7:0] ADDR_STAT = 8'h08;  // Status register
  localparam logic [1:0] TIME_PAGE = 2'h1;   // addr[7:6] of timing words

  // Control field positions
  localparam int CTRL_APU = 0;   // Active line pullup enable
  localparam int CTRL_SPU = 1;   // Strong pullup arm
  localparam int CTRL_OD = 2;    // Overdrive speed select
  localparam int CTRL_MRST = 3;  // Master reset, self clearing

  // Status field positions
  localparam int STAT_BUSY = 0;  // Slot in progress
  localparam int STAT_BIT = 1;   // Last sampled read bit
  localparam int STAT_SPU = 2;   // Strong pullup conducting
  localparam int STAT_APU = 3;   // Pullup transistor on
  localparam int STAT_ARM = 4;   // Trigger armed

  // Timing parameter indices within one speed set
  localparam logic [2:0] T_RSTL = 3'h0;  // reset_low_time
  localparam logic [2:0] T_RSTH = 3'h1;  // reset_high_time
  localparam logic [2:0] T_APU = 3'h2;   // active_pullup_duration
  localparam logic [2:0] T_W0L = 3'h3;   // write_zero_low_time
  localparam logic [2:0] T_W1L = 3'h4;   // write_one_low_time
  localparam logic [2:0] T_REC = 3'h5;   // recovery_time
  localparam logic [2:0] T_MSR = 3'h6;   // master_sample_read_time

  // Reset values of the timing words, in ticks; index 15 first
  localparam logic [15:0][15:0] TIME_DEF = {
    16'h0000, 16'h0014, 16'h000A, 16'h000A,
    16'h004B, 16'h000A, 16'h0271, 16'h0271,
    16'h0000, 16'h0064, 16'h0032, 16'h003C,
    16'h0258, 16'h0032, 16'h1388, 16'h1388
  };

  // Slot kinds, encoded in the command register low bits
  typedef enum logic [1:0] {
    SWPC_SLOT_RST,
    SWPC_SLOT_W0,
    SWPC_SLOT_W1,
    SWPC_SLOT_RD
  } swpc_slot_t;

  // Sequencer phases
  typedef enum logic [1:0] {
    SWPC_IDLE,
    SWPC_LOW,
    SWPC_HIGH1,
    SWPC_HIGH2
  } swpc_phase_t;

endpackage

// *** rtl/swpc_tick.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Tick divider: one-cycle enable every timing unit
// ****************************************************************
module swpc_tick (
  input wire logic core_clk,  // Core clock
  input wire logic resetn,    // Async reset, active low
  output logic tick           // One-cycle tick pulse
);

  typedef struct packed {
    logic [3:0] cnt;  // Cycle counter
    logic tick;       // Registered pulse
  } swpc_tick_st_t;

  swpc_tick_st_t st_r;   // State
  swpc_tick_st_t st_nxt; // Next state

  // Count core cycles and pulse on wrap
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == swpc_pkg::TICK_LAST) begin
      st_nxt.cnt = 4'h0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 4'h1;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule
`default_nettype wire

// *** rtl/swpc_tmem.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Timing word store: two speed sets, two registered read ports
// ****************************************************************
module swpc_tmem (
  input wire logic core_clk,         // Core clock
  input wire logic resetn,           // Async reset, active low
  input wire logic wr_en,            // Write strobe
  input wire logic [3:0] wr_idx,     // Write index
  input wire logic [15:0] wr_data,   // Write data
  input wire logic [3:0] rd_a_idx,   // Read port A index
  input wire logic [3:0] rd_b_idx,   // Read port B index
  output logic [15:0] rd_a,          // Read port A data
  output logic [15:0] rd_b           // Read port B data
);

  typedef struct packed {
    logic [15:0][15:0] mem;  // Timing words
    logic [15:0] a;          // Port A data
    logic [15:0] b;          // Port B data
  } swpc_tmem_st_t;

  swpc_tmem_st_t st_r;   // State
  swpc_tmem_st_t st_nxt; // Next state

  // Write one word, read two words
  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      st_nxt.mem[wr_idx] = wr_data;
    end
    st_nxt.a = st_r.mem[rd_a_idx];
    st_nxt.b = st_r.mem[rd_b_idx];
  end

  // State register, words start at their default timing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r.mem <= swpc_pkg::TIME_DEF;
      st_r.a <= 16'h0000;
      st_r.b <= 16'h0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_a = st_r.a;
  assign rd_b = st_r.b;

endmodule
`default_nettype wire

// *** verification/swpc_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Port checker for the pullup controller
// ****************************************************************
module swpc_assertions (
  input wire logic core_clk,          // Core clock
  input wire logic resetn,            // Async reset, active low
  input wire logic reg_rd,            // Read strobe
  input wire logic [31:0] reg_rdata,  // Read data
  input wire logic line_in,           // Line above threshold
  input wire logic line_low_oe,       // Drive line low
  input wire logic normal_pullup_en,  // Normal pullup on
  input wire logic apu_drive          // Pullup transistor on
);
  logic [15:0] since_low_r;   // Cycles since low drive
  logic [15:0] since_low_nxt; // Next count, saturating

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Saturating count, all ones means no recent slot
  always_comb begin
    since_low_nxt = since_low_r;
    if (line_low_oe) begin
      since_low_nxt = 16'h0000;
    end else if (since_low_r != 16'hFFFF) begin
      since_low_nxt = since_low_r + 16'h0001;
    end
  end

  // Count register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      since_low_r <= 16'hFFFF;
    end else begin
      since_low_r <= since_low_nxt;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_rdata_window: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("stray read data");
  a_rdata_clear: assert property
    ($past(reg_rd, 2) && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data held");
  a_drive_clash: assert property (!(apu_drive && line_low_oe))
    else $error("pullup clash");
  a_trig_delay: assert property ($rose(apu_drive) |->
    $past(line_in) && !$past(line_in, 2))
    else $error("untriggered pullup");
  a_pullup_pair: assert property ($past(resetn) |->
    normal_pullup_en == !line_low_oe)
    else $error("normal pullup wrong");
  a_low_min: assert property ($rose(line_low_oe) |-> line_low_oe[*4])
    else $error("low drive too short");
  a_apu_in_slot: assert property ($rose(apu_drive) |->
    since_low_r != 16'hFFFF)
    else $error("pullup outside slot");
  a_spu_yields: assert property ($rose(line_low_oe) |->
    !apu_drive && !$past(apu_drive))
    else $error("pullup on at slot start");

  cover property ($rose(apu_drive));
  cover property ($rose(line_low_oe));
  cover property (reg_rdata != 32'h0);
endmodule
`default_nettype wire

// *** verification/swpc_slave_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Slave on the open-drain line, with a slow rising edge
// ****************************************************************
module swpc_slave_model #(
  parameter int RISE = 3              // Cycles to cross the threshold
) (
  input wire logic core_clk,          // Core clock
  input wire logic resetn,            // Async reset, active low
  input wire logic line_low_oe,       // Master drives low
  input wire logic normal_pullup_en,  // Master normal pullup on
  input wire logic apu_drive,         // Master pullup transistor on
  input wire logic [7:0] hold_cyc,    // Read-zero hold from the fall
  input wire logic [7:0] pres_gap,    // Presence delay after reset low
  input wire logic [7:0] pres_len,    // Presence length, 0 for none
  input wire logic kick,              // Request a stray low pulse
  output logic line_in                // Line above threshold
);
  int rel;         // Cycles since line released
  int fall_t;      // Cycles since master fall
  int low_len;     // Master low length
  int pres_t;      // Since reset low end, -1 idle
  int kick_t;      // Stray pulse left
  logic slave_low; // Slave pulls the line low

  // Read zero, presence pulse or stray pulse
  always_comb begin
    slave_low = (fall_t < int'(hold_cyc)) || (kick_t > 0);
    if (pres_t >= RISE + int'(pres_gap) &&
        pres_t < RISE + int'(pres_gap) + int'(pres_len)) begin
      slave_low = 1'b1;
    end
  end

  // Released line rises after RISE cycles
  assign line_in = (rel >= RISE);

  // Line and slave timers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rel <= RISE;
      fall_t <= 255;
      low_len <= 0;
      pres_t <= -1;
      kick_t <= 0;
    end else begin
      if (line_low_oe || slave_low || !(normal_pullup_en || apu_drive)) begin
        rel <= 0;
      end else if (rel < RISE) begin
        rel <= rel + 1;
      end
      if (line_in && line_low_oe) begin
        fall_t <= 0;
      end else if (fall_t < 255) begin
        fall_t <= fall_t + 1;
      end
      low_len <= line_low_oe ? low_len + 1 : 0;
      if (!line_low_oe && low_len >= 35 && pres_len != 8'h00) begin
        pres_t <= 0;
      end else if (pres_t >= 0 && pres_t < 600) begin
        pres_t <= pres_t + 1;
      end
      kick_t <= kick ? 10 : (kick_t > 0 ? kick_t - 1 : 0);
    end
  end
endmodule
`default_nettype wire

// *** verification/single_wire_pullup_control_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Register-driven bench for the pullup controller
// ****************************************************************
module single_wire_pullup_control_tb;
  logic core_clk, resetn, reg_wr, reg_rd, kick;       // Bench drives
  logic [7:0] reg_addr, hold_cyc, pres_gap, pres_len; // Bench drives
  logic [31:0] reg_wdata, reg_rdata;                  // Register data
  logic line_in, line_low_oe, normal_pullup_en, apu_drive; // Line
  int bad_count = 0; // Mismatches
  int n_tests = 0;   // Comparisons
  int cycles = 0;    // Run length guard
  int r;             // Pulse counter
  logic [15:0] tw [16] = '{16'h8, 16'h14, 16'h3, 16'h6, 16'h2, 16'h2,
    16'h3, 16'h0, 16'hA, 16'hC, 16'h2, 16'h4, 16'h1, 16'h2, 16'h2, 16'h0};
  localparam logic [7:0] CTL = swpc_pkg::ADDR_CTRL; // Control address

  always #10 core_clk = ~core_clk;

  swpc_ctrl DUT (.*);

  swpc_slave_model u_slave (.core_clk(core_clk), .resetn(resetn),
    .line_low_oe(line_low_oe), .normal_pullup_en(normal_pullup_en),
    .apu_drive(apu_drive), .hold_cyc(hold_cyc), .pres_gap(pres_gap),
    .pres_len(pres_len), .kick(kick), .line_in(line_in));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic cyc;
    @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Read and compare masked
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e,
                     input string msg);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, e, msg);
  endtask

  // Run a slot: time low drive, count pulses
  task automatic run_slot(input logic [1:0] kind, input int lo,
                          input int fin, input int rises, input bit at_end);
    int n;
    int last;
    logic p;
    n = 0;
    last = 0;
    p = 1'b0;
    r = 0;
    wr(swpc_pkg::ADDR_CMD, {30'h0, kind});
    while (line_low_oe !== 1'b1 && n < 20) begin
      cyc();
      n++;
    end
    n = 0;
    while (line_low_oe === 1'b1 && n < 400) begin
      cyc();
      n++;
    end
    chk(32'(n >= lo * 5 - 1 && n <= lo * 5 + 1), 32'h1, "low time");
    for (int m = n; m < fin * 5 + 15; m++) begin
      cyc();
      if (apu_drive === 1'b1 && !p) r++;
      if (apu_drive === 1'b1) last = m + 1;
      p = apu_drive;
    end
    chk(32'(r), 32'(rises), "pulses");
    if (at_end) chk(32'(last >= fin * 5 - 3 && last <= fin * 5 + 3), 32'h1, "pullup end");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    {reg_wr, reg_rd, kick} = 3'h0;
    {reg_addr, hold_cyc, pres_gap, pres_len} = 32'h0;
    reg_wdata = 32'h0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    rdc(swpc_pkg::ADDR_STAT, 32'h1D, 32'h0, "status reset");
    rdc(CTL, 32'hF, 32'h0, "control reset");
    rdc(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped read");
    for (int i = 0; i < 16; i++) wr(8'h40 + 8'(4 * i), {16'h0, tw[i]});
    rdc(8'h44, 32'hFFFFFFFF, 32'h0, "timing word read");
    wr(CTL, 32'h1);
    pres_gap <= 8'h1E;
    pres_len <= 8'h1E;
    run_slot(2'h0, 8, 28, 2, 1);
    pres_len <= 8'h00;
    run_slot(2'h1, 6, 8, 1, 1);
    run_slot(2'h2, 2, 8, 1, 1);
    run_slot(2'h3, 2, 8, 1, 1);
    rdc(swpc_pkg::ADDR_STAT, 32'h3, 32'h2, "read one");
    hold_cyc <= 8'h14;
    run_slot(2'h3, 2, 8, 1, 1);
    rdc(swpc_pkg::ADDR_STAT, 32'h3, 32'h0, "read zero");
    hold_cyc <= 8'h00;
    wr(CTL, 32'h5);
    run_slot(2'h1, 4, 6, 1, 1);
    run_slot(2'h2, 1, 6, 1, 1);
    wr(CTL, 32'h0);
    run_slot(2'h1, 6, 8, 0, 0);
    // Idle stray pulse: no pullup
    wr(CTL, 32'h1);
    kick <= 1'b1;
    @(posedge core_clk);
    kick <= 1'b0;
    r = 0;
    repeat (40) begin
      cyc();
      if (apu_drive === 1'b1) r++;
    end
    chk(32'(r), 32'h0, "idle pullup");
    // Strong pullup ended by a command
    wr(CTL, 32'h3);
    run_slot(2'h2, 2, 8, 1, 0);
    chk({31'h0, apu_drive}, 32'h1, "spu held");
    rdc(swpc_pkg::ADDR_STAT, 32'hD, 32'hC, "spu status");
    rdc(CTL, 32'h3, 32'h3, "setting kept");
    run_slot(2'h1, 6, 8, 1, 1);
    rdc(CTL, 32'h3, 32'h1, "arm cleared");
    // Then ended by disable, by master reset
    for (int k = 0; k < 2; k++) begin
      wr(CTL, 32'h3);
      run_slot(2'h2, 2, 8, 1, 0);
      wr(CTL, (k == 0) ? 32'h1 : 32'h8);
      repeat (3) cyc();
      chk({31'h0, apu_drive}, 32'h0, "spu stop");
      rdc(CTL, 32'hF, 32'(1 - k), "ctrl after");
    end
    end_sim();
  end
endmodule

bind swpc_ctrl swpc_assertions u_chk (.core_clk(core_clk),
  .resetn(resetn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .line_in(line_in), .line_low_oe(line_low_oe),
  .normal_pullup_en(normal_pullup_en), .apu_drive(apu_drive));
`default_nettype wire
